// file: core/mmt_pkg.sv
// Purpose: Shared constants and types of the multi-mode timer control block.
// Assumes: Byte-wide register port with a 12-bit address, one timer per instance.
// Notes:   Every offset, field position, reset value and count lives here once.

package mmt_pkg;

    // Width of the register port address and data.
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // Register offsets of one timer.
    localparam logic [11:0] ADDR_COUNT_HIGH  = 12'hF00;
    localparam logic [11:0] ADDR_COUNT_LOW   = 12'hF01;
    localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hF02;
    localparam logic [11:0] ADDR_RELOAD_LOW  = 12'hF03;
    localparam logic [11:0] ADDR_PWM_HIGH    = 12'hF04;
    localparam logic [11:0] ADDR_PWM_LOW     = 12'hF05;
    localparam logic [11:0] ADDR_CHAIN_CFG   = 12'hF06;
    localparam logic [11:0] ADDR_SETUP       = 12'hF07;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'hF10;
    localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'hF11;
    localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'hF12;

    // Bit position of the chain select in the chain configuration register.
    localparam int unsigned CHAIN_SELECT_BIT = 4;

    // Interrupt status bit positions.
    localparam int unsigned IRQ_RELOAD_BIT  = 0;
    localparam int unsigned IRQ_CAPTURE_BIT = 1;
    localparam int unsigned IRQ_GATE_BIT    = 2;
    localparam int unsigned IRQ_W           = 3;

    // Reset values.
    localparam logic [7:0]  SETUP_RESET     = 8'h00;
    localparam logic [15:0] PWM_RESET       = 16'h0000;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;
    localparam logic [15:0] RELOAD_RESET    = 16'hFFFF;
    localparam logic [2:0]  IRQ_RESET       = 3'h0;

    // Value the counter restarts from after every reload or capture.
    localparam logic [15:0] COUNT_RESTART   = 16'h0001;

    // Width of the free-running prescale counter, enough for divide by 128.
    localparam int unsigned PRESCALE_W = 7;

    // Encoding of the operating mode field.
    typedef enum logic [2:0] {
        MODE_ONE_SHOT   = 3'h0,
        MODE_CONTINUOUS = 3'h1,
        MODE_COUNTER    = 3'h2,
        MODE_PWM        = 3'h3,
        MODE_CAPTURE    = 3'h4,
        MODE_COMPARE    = 3'h5,
        MODE_GATED      = 3'h6,
        MODE_CAP_CMP    = 3'h7
    } mmt_mode_t;

    // Layout of the setup register, bit 7 down to bit 0.
    typedef struct packed {
        logic       countEnable;
        logic       ioPolarity;
        logic [2:0] clockDivideSel;
        mmt_mode_t  operatingModeSel;
    } mmt_setup_t;

    // One register port request.
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } mmt_bus_req_t;

endpackage

// file: core/multi_mode_timer_control.sv
// Purpose: One 16-bit general-purpose timer with eight operating modes.
// Assumes: Register port strobes are one cycle long and never overlap.
// Notes:   The pin input is filtered; the partner output needs no filter.

`timescale 1ns/1ns
`default_nettype none

module multi_mode_timer_control
    import mmt_pkg::*;
(
    input  wire logic         sys_clk,         // System clock, 125 MHz.
    input  wire logic         reset,           // Asynchronous reset, active high.
    input  wire mmt_bus_req_t busReq,          // Register port request.
    output var  logic [7:0]   readData,        // Read data, valid one cycle after rd.
    input  wire logic         timerInPin,      // Timer input pin, asynchronous.
    input  wire logic         partnerTimerOut, // Output of the partner timer.
    output var  logic         timerOut,        // Timer output pin.
    output var  logic         timerIrq         // Level interrupt request.
);

    // Pin synchroniser and filter state.
    logic        pinSync1_reg;      // First stage, read only by the second.
    logic        pinSync2_reg;      // Second stage.
    logic        pinSync3_reg;      // Third stage.
    logic        pinLevel_reg;      // Filtered pin level.
    logic        pinLevel_next;     // Next filtered level.

    // Selected timer input and its previous value for edge detection.
    logic        selIn;             // Input after the chain select.
    logic        prevIn_reg;        // Selected input one cycle ago.
    logic        riseEdge;          // Rising edge of the selected input.
    logic        fallEdge;          // Falling edge of the selected input.
    logic        polEdge;           // Edge direction chosen by polarity.
    logic        gateActive;        // Gated mode counting level present.
    logic        gateEndEdge;       // Edge that ends a gated interval.

    // Software visible registers.
    mmt_setup_t  setup_reg;         // Enable, polarity, prescale and mode.
    mmt_setup_t  setup_next;        // Next setup value.
    logic        chainSel_reg;      // Chain select bit.
    logic        chainSel_next;     // Next chain select bit.
    logic [15:0] count_reg;         // Running count.
    logic [15:0] count_next;        // Next count.
    logic [15:0] reload_reg;        // Reload or compare value.
    logic [15:0] reload_next;       // Next reload value.
    logic [7:0]  reloadHold_reg;    // Staged reload high byte.
    logic [7:0]  reloadHold_next;   // Next staged reload high byte.
    logic [15:0] pwmMatch_reg;      // PWM match or captured value.
    logic [15:0] pwmMatch_next;     // Next PWM match value.
    logic [7:0]  lowHold_reg;       // Low count byte latched on high read.
    logic [7:0]  lowHold_next;      // Next latched low byte.

    // Timer core state.
    logic [6:0]  prescale_reg;      // Free-running prescale counter.
    logic [6:0]  prescale_next;     // Next prescale count.
    logic [6:0]  prescaleMask;      // Low bits that must be all ones for a tick.
    logic        started_reg;       // Capture/compare run has begun.
    logic        started_next;      // Next started flag.
    logic        out_reg;           // Timer output flip-flop.
    logic        out_next;          // Next timer output.
    logic        srcEvent;          // One event of the timer input clock.
    logic        tick;              // One count step after the prescaler.
    logic        atReload;          // Count equals the reload value.

    // Events that feed the interrupt status.
    logic        evReload;          // Reload or compare reached.
    logic        evCapture;         // Count captured.
    logic        evGate;            // Gated interval ended.

    // Interrupt registers.
    logic [2:0]  irqStatus_reg;     // Sticky event bits.
    logic [2:0]  irqStatus_next;    // Next status bits.
    logic [2:0]  irqEnable_reg;     // Interrupt enable mask.
    logic [2:0]  irqEnable_next;    // Next enable mask.
    logic [2:0]  irqClear;          // Bits written to the clear register.
    logic [2:0]  irqEvents;         // Events of this cycle.
    logic        irq_reg;           // Registered interrupt output.
    logic        irq_next;          // Next interrupt level.

    // Read data register.
    logic [7:0]  readData_reg;      // Read data of the previous strobe.
    logic [7:0]  readData_next;     // Next read data.

    // Filter: the level changes once the second and third stage agree.
    always_comb begin
        pinLevel_next = pinLevel_reg;
        if (pinSync2_reg == pinSync3_reg) begin
            pinLevel_next = pinSync3_reg;
        end
    end

    // Synchroniser chain and filtered level.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pinSync1_reg <= 1'b0;
            pinSync2_reg <= 1'b0;
            pinSync3_reg <= 1'b0;
            pinLevel_reg <= 1'b0;
        end else begin
            pinSync1_reg <= timerInPin;
            pinSync2_reg <= pinSync1_reg;
            pinSync3_reg <= pinSync2_reg;
            pinLevel_reg <= pinLevel_next;
        end
    end

    // The partner output shares this clock, so it is used directly.
    assign selIn = chainSel_reg ? partnerTimerOut : pinLevel_reg;

    // Edge detection on the selected input.
    assign riseEdge    = selIn & ~prevIn_reg;
    assign fallEdge    = ~selIn & prevIn_reg;
    assign polEdge     = setup_reg.ioPolarity ? fallEdge : riseEdge;
    assign gateActive  = setup_reg.ioPolarity ? ~selIn : selIn;
    assign gateEndEdge = setup_reg.ioPolarity ? riseEdge : fallEdge;

    // A tick falls when the low prescale bits selected by the field are all ones.
    assign prescaleMask = 7'((8'h01 << setup_reg.clockDivideSel) - 8'h01);
    assign atReload     = (count_reg == reload_reg);

    // Timer core and register writes; software writes come last and win,
    // except that a hardware capture beats a PWM byte write in the same cycle.
    always_comb begin
        setup_next      = setup_reg;
        chainSel_next   = chainSel_reg;
        count_next      = count_reg;
        reload_next     = reload_reg;
        reloadHold_next = reloadHold_reg;
        pwmMatch_next   = pwmMatch_reg;
        prescale_next   = prescale_reg;
        started_next    = started_reg;
        out_next        = out_reg;
        srcEvent        = 1'b0;
        tick            = 1'b0;
        evReload        = 1'b0;
        evCapture       = 1'b0;
        evGate          = 1'b0;

        if (!setup_reg.countEnable) begin
            // Idle: prescaler cleared, output parked at the polarity level.
            prescale_next = '0;
            started_next  = 1'b0;
            out_next      = setup_reg.ioPolarity;
        end else begin
            // Pick what one step of the timer input clock is in this mode.
            case (setup_reg.operatingModeSel)
                MODE_COUNTER: begin
                    srcEvent = polEdge;
                end
                MODE_GATED: begin
                    srcEvent = gateActive;
                end
                MODE_CAP_CMP: begin
                    srcEvent = started_reg;
                end
                default: begin
                    srcEvent = 1'b1;
                end
            endcase

            // Power-of-two prescaler driven by the source events.
            if (srcEvent) begin
                prescale_next = prescale_reg + 7'h01;
                tick          = ((prescale_reg & prescaleMask) == prescaleMask);
            end

            // Count step and reload at the reload or compare value.
            if (tick) begin
                if (atReload) begin
                    count_next = COUNT_RESTART;
                    evReload   = 1'b1;
                end else begin
                    count_next = count_reg + 16'h0001;
                end
            end

            // Output behaviour on reload and on PWM match.
            if (setup_reg.operatingModeSel == MODE_PWM) begin
                if (evReload) begin
                    out_next = setup_reg.ioPolarity;
                end else if (tick && (count_reg == pwmMatch_reg)) begin
                    out_next = ~setup_reg.ioPolarity;
                end
            end else if (evReload) begin
                out_next = ~out_reg;
            end

            // A one-shot run stops itself at its first reload.
            if (evReload && (setup_reg.operatingModeSel == MODE_ONE_SHOT)) begin
                setup_next.countEnable = 1'b0;
            end

            // Capture handling and gated interval end.
            case (setup_reg.operatingModeSel)
                MODE_CAPTURE: begin
                    if (polEdge) begin
                        pwmMatch_next = count_reg;
                        count_next    = COUNT_RESTART;
                        evCapture     = 1'b1;
                    end
                end
                MODE_CAP_CMP: begin
                    if (polEdge && !started_reg) begin
                        started_next = 1'b1;
                    end else if (polEdge) begin
                        pwmMatch_next = count_reg;
                        count_next    = COUNT_RESTART;
                        evCapture     = 1'b1;
                    end
                end
                MODE_GATED: begin
                    evGate = gateEndEdge;
                end
                default: begin
                    evGate = 1'b0;
                end
            endcase
        end

        // Software writes.
        if (busReq.wr) begin
            case (busReq.addr)
                ADDR_COUNT_HIGH: begin
                    count_next[15:8] = busReq.wdata;
                end
                ADDR_COUNT_LOW: begin
                    count_next[7:0] = busReq.wdata;
                end
                ADDR_RELOAD_HIGH: begin
                    // Staged until the low byte arrives, for a 16-bit update.
                    reloadHold_next = busReq.wdata;
                end
                ADDR_RELOAD_LOW: begin
                    reload_next = {reloadHold_reg, busReq.wdata};
                end
                ADDR_PWM_HIGH: begin
                    if (!evCapture) begin
                        pwmMatch_next[15:8] = busReq.wdata;
                    end
                end
                ADDR_PWM_LOW: begin
                    if (!evCapture) begin
                        pwmMatch_next[7:0] = busReq.wdata;
                    end
                end
                ADDR_CHAIN_CFG: begin
                    chainSel_next = busReq.wdata[CHAIN_SELECT_BIT];
                end
                ADDR_SETUP: begin
                    setup_next = mmt_setup_t'(busReq.wdata);
                end
                default: chainSel_next = chainSel_reg;
            endcase
        end
    end

    // Timer core and register storage.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            setup_reg      <= mmt_setup_t'(SETUP_RESET);
            chainSel_reg   <= 1'b0;
            count_reg      <= COUNT_RESET;
            reload_reg     <= RELOAD_RESET;
            reloadHold_reg <= RELOAD_RESET[15:8];
            pwmMatch_reg   <= PWM_RESET;
            prescale_reg   <= '0;
            started_reg    <= 1'b0;
            out_reg        <= 1'b0;
            prevIn_reg     <= 1'b0;
        end else begin
            setup_reg      <= setup_next;
            chainSel_reg   <= chainSel_next;
            count_reg      <= count_next;
            reload_reg     <= reload_next;
            reloadHold_reg <= reloadHold_next;
            pwmMatch_reg   <= pwmMatch_next;
            prescale_reg   <= prescale_next;
            started_reg    <= started_next;
            out_reg        <= out_next;
            prevIn_reg     <= selIn;
        end
    end

    // Interrupt status: a set in the cycle of its clear still lands.
    always_comb begin
        irqEvents = '0;
        irqEvents[IRQ_RELOAD_BIT]  = evReload;
        irqEvents[IRQ_CAPTURE_BIT] = evCapture;
        irqEvents[IRQ_GATE_BIT]    = evGate;
        irqClear       = '0;
        irqEnable_next = irqEnable_reg;
        if (busReq.wr && (busReq.addr == ADDR_IRQ_CLEAR)) begin
            irqClear = busReq.wdata[2:0];
        end
        if (busReq.wr && (busReq.addr == ADDR_IRQ_ENABLE)) begin
            irqEnable_next = busReq.wdata[2:0];
        end
        irqStatus_next = (irqStatus_reg & ~irqClear) | irqEvents;
        irq_next       = |(irqStatus_next & irqEnable_next);
    end

    // Interrupt storage.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irqStatus_reg <= IRQ_RESET;
            irqEnable_reg <= IRQ_RESET;
            irq_reg       <= 1'b0;
        end else begin
            irqStatus_reg <= irqStatus_next;
            irqEnable_reg <= irqEnable_next;
            irq_reg       <= irq_next;
        end
    end

    // Read mux; data stand for one cycle only, zero otherwise.
    always_comb begin
        readData_next = 8'h00;
        lowHold_next  = lowHold_reg;
        if (busReq.rd) begin
            case (busReq.addr)
                ADDR_COUNT_HIGH: begin
                    readData_next = count_reg[15:8];
                    if (setup_reg.countEnable) begin
                        lowHold_next = count_reg[7:0];
                    end
                end
                ADDR_COUNT_LOW: begin
                    // Latched byte while running, live byte while stopped.
                    readData_next = setup_reg.countEnable ? lowHold_reg
                                                          : count_reg[7:0];
                end
                ADDR_RELOAD_HIGH: begin
                    readData_next = reload_reg[15:8];
                end
                ADDR_RELOAD_LOW: begin
                    readData_next = reload_reg[7:0];
                end
                ADDR_PWM_HIGH: begin
                    readData_next = pwmMatch_reg[15:8];
                end
                ADDR_PWM_LOW: begin
                    readData_next = pwmMatch_reg[7:0];
                end
                ADDR_CHAIN_CFG: begin
                    readData_next[CHAIN_SELECT_BIT] = chainSel_reg;
                end
                ADDR_SETUP: begin
                    readData_next = setup_reg;
                end
                ADDR_IRQ_STATUS: begin
                    readData_next = {5'h00, irqStatus_reg};
                end
                ADDR_IRQ_ENABLE: begin
                    readData_next = {5'h00, irqEnable_reg};
                end
                default: begin
                    // Unmapped and write-only addresses read as zero.
                    readData_next = 8'h00;
                end
            endcase
        end
    end

    // Read data and low byte holding storage.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            readData_reg <= 8'h00;
            lowHold_reg  <= 8'h00;
        end else begin
            readData_reg <= readData_next;
            lowHold_reg  <= lowHold_next;
        end
    end

    // Outputs come straight from flip-flops.
    assign readData = readData_reg;
    assign timerOut = out_reg;
    assign timerIrq = irq_reg;

endmodule

`default_nettype wire

// file: testbench/mmt_asserts.sv
// Purpose: Port checker of the timer block.
// Assumes: One clock domain with an asynchronous reset.
// Notes:   Bound to every instance of the timer.
`timescale 1ns/1ns
`default_nettype none
module mmt_asserts
    import mmt_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         reset,
    input wire mmt_bus_req_t busReq,
    input wire logic [7:0]   readData,
    input wire logic         timerInPin,
    input wire logic         partnerTimerOut,
    input wire logic         timerOut,
    input wire logic         timerIrq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // A write or a read of one address.
    sequence wrAt(a); busReq.wr && busReq.addr == a; endsequence
    sequence rdAt(a); busReq.rd && busReq.addr == a; endsequence
    AST_SETUP_RB: assert property (wrAt(ADDR_SETUP) ##1 rdAt(ADDR_SETUP) |=>
        readData[6:0] == $past(busReq.wdata[6:0], 2)) else $error("setup readback");
    AST_CHAIN_RB: assert property (wrAt(ADDR_CHAIN_CFG) ##1 rdAt(ADDR_CHAIN_CFG) |=>
        readData[4] == $past(busReq.wdata[4], 2)) else $error("chain readback");
    AST_IDLE_OUT: assert property (busReq.wr && busReq.addr == ADDR_SETUP &&
        !busReq.wdata[7] |-> ##2 timerOut == $past(busReq.wdata[6], 2)) else $error("idle out");
    AST_RD_IDLE: assert property (!$past(busReq.rd) |-> readData == 8'h00)
        else $error("read data outside slot");
    AST_UNMAPPED: assert property (rdAt(12'hF08) |=> readData == 8'h00)
        else $error("unmapped read");
    AST_CLR_RD: assert property (rdAt(ADDR_IRQ_CLEAR) |=> readData == 8'h00)
        else $error("clear register read");
    AST_IRQ_MASK: assert property (busReq.wr && busReq.addr == ADDR_IRQ_ENABLE &&
        busReq.wdata[2:0] == 3'h0 |-> ##2 !timerIrq) else $error("masked irq");
    AST_STAT_RSV: assert property (rdAt(ADDR_IRQ_STATUS) |=> readData[7:3] == 5'h00)
        else $error("status spare bits");
endmodule
bind multi_mode_timer_control mmt_asserts u_asserts (.sys_clk(sys_clk), .reset(reset),
    .busReq(busReq), .readData(readData), .timerInPin(timerInPin),
    .partnerTimerOut(partnerTimerOut), .timerOut(timerOut), .timerIrq(timerIrq));
`default_nettype wire

// file: testbench/mmt_pin_model.sv
// Purpose: Far side of the timer: input pin and partner timer output.
// Assumes: Both lines toggle on the system clock.
// Notes:   The pin rests low while muted or stopped.
`timescale 1ns/1ns
`default_nettype none
module mmt_pin_model (
    input  wire logic       sys_clk,
    input  wire logic       pulseGo,
    input  wire logic       pinMute,
    input  wire logic [3:0] halfPeriod,
    output var  logic       timerInPin,
    output var  logic       partnerTimerOut
);
    logic [3:0] tick = 4'h0; // Cycles since the last toggle.
    // The partner line, and the pin unless muted, toggle every halfPeriod+1 cycles while running.
    always @(posedge sys_clk) begin
        tick <= (tick >= halfPeriod) ? 4'h0 : tick + 4'h1;
        if (!pulseGo) begin
            timerInPin <= 1'b0;
            partnerTimerOut <= 1'b0;
        end else if (tick >= halfPeriod) begin
            timerInPin <= ~timerInPin & ~pinMute;
            partnerTimerOut <= ~partnerTimerOut;
        end
    end
endmodule
`default_nettype wire

// file: testbench/multi_mode_timer_control_bench.sv
// Purpose: Self-checking bench of the timer block.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Every wait is bounded.
`timescale 1ns/1ns
`default_nettype none
module multi_mode_timer_control_bench
    import mmt_pkg::*;
;
    logic         sys_clk, reset, timerOut, timerIrq, pulseGo, pinMute, pin, partner;
    mmt_bus_req_t busReq;
    logic [7:0]   readData;
    int           fails, nChecks, n;
    multi_mode_timer_control dut (.sys_clk(sys_clk), .reset(reset), .busReq(busReq),
        .readData(readData), .timerInPin(pin), .partnerTimerOut(partner),
        .timerOut(timerOut), .timerIrq(timerIrq));
    mmt_pin_model far (.sys_clk(sys_clk), .pulseGo(pulseGo), .pinMute(pinMute),
        .halfPeriod(4'h3), .timerInPin(pin), .partnerTimerOut(partner));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        nChecks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", s, e, g);
        end
    endtask
    // One access: 0 write, 1 read, 2 write then read at once.
    task automatic acc(input logic [11:0] a, input logic [7:0] d, input int m,
                       input logic [7:0] e = 8'h00);
        @(posedge sys_clk);
        busReq <= '{addr: a, wdata: d, wr: m != 1, rd: m == 1};
        if (m == 2) begin
            @(posedge sys_clk);
            busReq <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
        end
        @(posedge sys_clk);
        busReq <= '0;
        @(negedge sys_clk);
        if (m != 0) chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, readData});
    endtask
    // Counts cycles until the output changes.
    task automatic waitEdge();
        logic v;
        v = timerOut;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (timerOut === v && n < 900);
        if (n >= 900) begin
            fails++;
            end_of_test();
        end
    endtask
    // Disables with a new setup and restarts the count at one.
    task automatic prep(input logic [7:0] s);
        acc(ADDR_SETUP, s, 0);
        acc(ADDR_COUNT_HIGH, 8'h00, 0);
        acc(ADDR_COUNT_LOW, 8'h01, 0);
    endtask
    task automatic s_regs();
        acc(ADDR_PWM_LOW, 8'h00, 1, 8'h00);
        acc(ADDR_SETUP, 8'h00, 1, 8'h00);
        acc(ADDR_CHAIN_CFG, 8'h00, 1, 8'h00);
        acc(12'hF08, 8'h00, 1, 8'h00);
        for (int m = 0; m < 8; m++) acc(ADDR_SETUP, {1'b0, m[0], m[2:0], m[2:0]}, 2,
            {1'b0, m[0], m[2:0], m[2:0]});
        acc(ADDR_CHAIN_CFG, 8'h10, 2, 8'h10);
    endtask
    task automatic s_prescale();
        // The reload high byte resets to FF and is only staged, so clear it first.
        acc(ADDR_RELOAD_HIGH, 8'h00, 0);
        acc(ADDR_RELOAD_LOW, 8'h03, 0);
        for (int p = 0; p < 4; p++) begin
            prep({2'b00, p[2:0], MODE_CONTINUOUS});
            acc(ADDR_SETUP, {2'b10, p[2:0], MODE_CONTINUOUS}, 0);
            waitEdge();
            waitEdge();
            chk("reload period", 16'(3 << p), 16'(n));
        end
    endtask
    task automatic s_pwm();
        acc(ADDR_RELOAD_LOW, 8'h07, 0);
        acc(ADDR_PWM_LOW, 8'h03, 0);
        for (int p = 0; p < 2; p++) begin
            prep({1'b0, p[0], 3'h0, MODE_PWM});
            chk("idle out", 16'(p), {15'h0, timerOut});
            acc(ADDR_SETUP, {1'b1, p[0], 3'h0, MODE_PWM}, 0);
            waitEdge();
            waitEdge();
            chk("pwm width", 16'h4, 16'(n));
        end
    endtask
    task automatic s_irq();
        acc(ADDR_IRQ_ENABLE, 8'h01, 0);
        chk("irq", 16'h1, {15'h0, timerIrq});
        acc(ADDR_IRQ_STATUS, 8'h00, 1, 8'h01);
        prep(8'h00);
        acc(ADDR_IRQ_CLEAR, 8'h07, 0);
        chk("irq", 16'h0, {15'h0, timerIrq});
        acc(ADDR_IRQ_ENABLE, 8'h00, 0);
    endtask
    // Runs setup s with chain c for 40 cycles and checks the status bits.
    task automatic s_chain(input logic [7:0] c, input logic [7:0] s, input logic [7:0] e);
        prep({1'b0, s[6:0]});
        acc(ADDR_IRQ_CLEAR, 8'h07, 0);
        acc(ADDR_CHAIN_CFG, c, 0);
        acc(ADDR_SETUP, s, 0);
        repeat (40) @(posedge sys_clk);
        acc(ADDR_IRQ_STATUS, 8'h00, 1, e);
    endtask
    // Enabled and idle at count 1: the low byte read returns the latched byte.
    task automatic s_latch();
        acc(ADDR_COUNT_HIGH, 8'h00, 1, 8'h00);
        acc(ADDR_COUNT_LOW, 8'h55, 0);
        acc(ADDR_COUNT_LOW, 8'h00, 1, 8'h01);
        acc(ADDR_SETUP, 8'h02, 0);
        acc(ADDR_COUNT_LOW, 8'h00, 1, 8'h55);
    endtask
    // Partner period of 8 cycles, one capture edge each: each capture holds a count of 8.
    task automatic s_capture();
        acc(ADDR_RELOAD_LOW, 8'hFF, 0);
        for (int q = 0; q < 4; q++) begin
            s_chain(8'h10, {1'b1, q[0], 3'h0, q[1] ? MODE_CAP_CMP : MODE_CAPTURE}, 8'h02);
            acc(ADDR_PWM_LOW, 8'h00, 1, 8'h08);
            if (q < 2) s_chain(8'h10, {1'b1, q[0], 3'h0, MODE_GATED}, 8'h04);
        end
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        reset = 1'b1;
        busReq = '0;
        pulseGo = 1'b0;
        pinMute = 1'b1;
        fails = 0;
        nChecks = 0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        s_regs();
        s_prescale();
        s_pwm();
        s_irq();
        pulseGo <= 1'b1;
        acc(ADDR_RELOAD_LOW, 8'h02, 0);
        s_chain(8'h00, 8'h82, 8'h00);
        s_latch();
        s_chain(8'h10, 8'h82, 8'h01);
        s_chain(8'h10, {5'h10, MODE_COMPARE}, 8'h01);
        s_chain(8'h10, 8'h80, 8'h01);
        acc(ADDR_SETUP, 8'h00, 1, 8'h00);
        pinMute <= 1'b0;
        s_chain(8'h00, 8'h82, 8'h01);
        s_capture();
        end_of_test();
    end
endmodule
`default_nettype wire
